// file: rtl/vffpc_regs.svh
// Constants shared by both ends of the field memory link.
// Functional notes
// - Host keeps store pointer 200 to 262223 ahead.
// - Host keeps pointers equal for one-field delay.
// - Array transfers happen only in 64-word blocks.
// - Old data past clear point may be lost.
// - Store clear flushes register block to array.
// - Store clears at least 82 addresses apart.
// - Pointer wrap to zero acts as clear.
// - Fetch clears at least 82 addresses apart.
// - Fetch gate never raised at address zero.
// - Park fetch pointer by holding fetch clear.
// - Held fetch clear rereads address zero each cycle.
// - Store gate low captures one byte per edge.
// - Released gate freezes pointer, resumes from there.
// - Drive off hides data, pointer still advances.
// - Clear cycle transfers the word at address zero.
`ifndef VFFPC_REGS_SVH
`define VFFPC_REGS_SVH
`define VFFPC_FIELD_WORDS 262224
`define VFFPC_BLOCK_WORDS 64
`define VFFPC_WORD_BITS 8
`define VFFPC_LEAD_MIN 200
`define VFFPC_CLEAR_GAP 82
`define VFFPC_FIFO_DEPTH 16
`define VFFPC_CNT_BITS 9
`endif

// file: rtl/vffpc_pkg.sv
// Types shared by both ends of the field memory link.
package vffpc_pkg;
    typedef logic [7:0] vffpc_byte_t;
    typedef enum logic [1:0]
    {
        VFFPC_IDLE = 2'b00,
        VFFPC_LEAD = 2'b01,
        VFFPC_RUN = 2'b10
    } vffpc_state_e;
endpackage

// file: rtl/vffpc_if.sv
// Pin bundle between the field memory and the video logic that drives it.
`timescale 1ns/1ns
interface vffpc_if;
    import vffpc_pkg::*;
    vffpc_byte_t input_byte;
    logic store_gate_n;
    logic store_pointer_clear_n;
    logic fetch_gate_n;
    logic fetch_pointer_clear_n;
    logic output_drive_n;
    vffpc_byte_t output_byte;
    logic output_byte_oe;

    modport device
    (
        input input_byte,
        input store_gate_n,
        input store_pointer_clear_n,
        input fetch_gate_n,
        input fetch_pointer_clear_n,
        input output_drive_n,
        output output_byte,
        output output_byte_oe
    );

    modport host
    (
        output input_byte,
        output store_gate_n,
        output store_pointer_clear_n,
        output fetch_gate_n,
        output fetch_pointer_clear_n,
        output output_drive_n,
        input output_byte,
        input output_byte_oe
    );
endinterface

// file: rtl/vffpc_device.sv
// Field memory end: block-organised store and fetch ports over one cell array.
`timescale 1ns/1ns
`include "vffpc_regs.svh"
module vffpc_device #(
    parameter int DEPTH = `VFFPC_FIELD_WORDS,
    parameter int BLOCK = `VFFPC_BLOCK_WORDS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link to the video logic
    vffpc_if.device port,
    // Pointer observation
    output logic [$clog2(DEPTH)-1:0] o_store_addr,
    output logic [$clog2(DEPTH)-1:0] o_fetch_addr
);
    import vffpc_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int BW = $clog2(BLOCK);
    localparam int BLOCKS = (DEPTH + BLOCK - 1) / BLOCK;
    localparam int WB = `VFFPC_WORD_BITS;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [BW-1:0] BLK_END = BW'(BLOCK - 1);

    // Word offsets are sliced straight out of the pointer, so block sizes other than a power of two cannot be served.
    if (BLOCK < 2 || (1 << BW) != BLOCK || DEPTH <= BLOCK)
    begin : g_bad_block
        $error("vffpc_device: BLOCK must be a power of two below DEPTH");
    end

    // The array is only ever touched a whole block at a time.
    logic [BLOCK*WB-1:0] mem [BLOCKS];

    logic [AW-1:0] sptr_reg;
    logic [AW-1:0] sptr_next;
    logic spend_reg;
    logic spend_next;
    logic [BLOCK*WB-1:0] wbuf_reg;
    logic [BLOCK*WB-1:0] wbuf_next;
    logic flush_en;
    logic [AW-BW-1:0] flush_blk;
    logic [BLOCK*WB-1:0] flush_data;

    logic [AW-1:0] fptr_reg;
    logic [AW-1:0] fptr_next;
    logic fpend_reg;
    logic fpend_next;
    logic [BLOCK*WB-1:0] rbuf_reg;
    logic [BLOCK*WB-1:0] rbuf_next;
    vffpc_byte_t dout_reg;
    vffpc_byte_t dout_next;
    logic oe_reg;
    logic oe_next;

    // Store port next state.
    always_comb
    begin
        logic s_en;
        logic s_clr;
        logic [AW-1:0] s_addr;
        s_en = ~port.store_gate_n;
        // A clear seen while gated off waits for the next enabled cycle.
        s_clr = ~port.store_pointer_clear_n | spend_reg;
        s_addr = s_clr ? '0 : sptr_reg;
        sptr_next = sptr_reg;
        wbuf_next = wbuf_reg;
        spend_next = s_en ? 1'b0 : s_clr;
        flush_en = 1'b0;
        flush_blk = sptr_reg[AW-1:BW];
        flush_data = wbuf_reg;
        if (s_en)
        begin
            wbuf_next[{s_addr[BW-1:0], 3'b000} +: WB] = port.input_byte;
            if (s_clr && sptr_reg[BW-1:0] != '0)
            begin
                // Stale words past the clear point go out with the block.
                flush_en = 1'b1;
            end
            else if (s_addr[BW-1:0] == BLK_END || s_addr == LAST)
            begin
                flush_en = 1'b1;
                flush_blk = s_addr[AW-1:BW];
                flush_data = wbuf_next;
            end
            sptr_next = (s_addr == LAST) ? '0 : s_addr + 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sptr_reg <= '0;
            spend_reg <= 1'b0;
            wbuf_reg <= '0;
        end
        else
        begin
            sptr_reg <= sptr_next;
            spend_reg <= spend_next;
            wbuf_reg <= wbuf_next;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (flush_en)
        begin
            mem[flush_blk] <= flush_data;
        end
    end

    // Fetch port next state.
    always_comb
    begin
        logic f_en;
        logic f_clr;
        logic [AW-1:0] f_addr;
        logic [BLOCK*WB-1:0] f_blk;
        f_en = ~port.fetch_gate_n;
        f_clr = ~port.fetch_pointer_clear_n | fpend_reg;
        f_addr = f_clr ? '0 : fptr_reg;
        f_blk = mem[f_addr[AW-1:BW]];
        fptr_next = fptr_reg;
        rbuf_next = rbuf_reg;
        dout_next = dout_reg;
        fpend_next = f_en ? 1'b0 : f_clr;
        oe_next = ~port.output_drive_n;
        if (f_en)
        begin
            if (f_addr[BW-1:0] == '0)
            begin
                // Entering a block reloads it, so a held clear sees fresh data.
                rbuf_next = f_blk;
                dout_next = f_blk[WB-1:0];
            end
            else
            begin
                dout_next = rbuf_reg[{f_addr[BW-1:0], 3'b000} +: WB];
            end
            fptr_next = (f_addr == LAST) ? '0 : f_addr + 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            fptr_reg <= '0;
            fpend_reg <= 1'b0;
            rbuf_reg <= '0;
            dout_reg <= '0;
            oe_reg <= 1'b0;
        end
        else
        begin
            fptr_reg <= fptr_next;
            fpend_reg <= fpend_next;
            rbuf_reg <= rbuf_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
        end
    end

    assign port.output_byte = dout_reg;
    assign port.output_byte_oe = oe_reg;
    assign o_store_addr = sptr_reg;
    assign o_fetch_addr = fptr_reg;
endmodule

// file: rtl/vffpc_host.sv
// Video logic end: input FIFO and the sequencer that drives the field memory.
`timescale 1ns/1ns
`include "vffpc_regs.svh"
module vffpc_fifo #(
    parameter int WIDTH = `VFFPC_WORD_BITS,
    parameter int DEPTH = `VFFPC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_bad_depth
        $error("vffpc_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wp_reg;
    logic [PW:0] wp_next;
    logic [PW:0] rp_reg;
    logic [PW:0] rp_next;
    logic push;
    logic pop;

    always_comb
    begin
        o_in_ready = (wp_reg[PW] == rp_reg[PW]) || (wp_reg[PW-1:0] != rp_reg[PW-1:0]);
        o_out_valid = wp_reg != rp_reg;
        push = i_in_valid & o_in_ready;
        pop = o_out_valid & i_out_ready;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wp_reg[PW-1:0]] <= i_in_data;
        end
    end

    assign o_out_data = mem[rp_reg[PW-1:0]];
endmodule

module vffpc_host (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link to the field memory
    vffpc_if.host port,
    // Incoming video words
    input wire logic i_pix_valid,
    input wire vffpc_pkg::vffpc_byte_t i_pix_data,
    output logic o_pix_ready,
    // Field control
    input wire logic i_field_start,
    input wire logic i_new_mode,
    input wire logic i_park,
    output logic o_start_taken,
    // Outgoing delayed video words
    output logic o_vid_valid,
    output vffpc_pkg::vffpc_byte_t o_vid_data
);
    import vffpc_pkg::*;

    localparam logic [`VFFPC_CNT_BITS-1:0] LEAD = `VFFPC_CNT_BITS'(`VFFPC_LEAD_MIN);
    localparam logic [`VFFPC_CNT_BITS-1:0] GAP = `VFFPC_CNT_BITS'(`VFFPC_CLEAR_GAP);
    localparam logic [`VFFPC_CNT_BITS-1:0] CNT_MAX = '1;

    logic drain_ready;
    logic fifo_valid;
    vffpc_byte_t fifo_data;

    vffpc_fifo #(.WIDTH(`VFFPC_WORD_BITS), .DEPTH(`VFFPC_FIFO_DEPTH)) u_fifo
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(i_pix_valid),
        .i_in_data(i_pix_data),
        .o_in_ready(o_pix_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(drain_ready)
    );

    vffpc_state_e state_reg;
    vffpc_state_e state_next;
    logic [`VFFPC_CNT_BITS-1:0] cnt_reg;
    logic [`VFFPC_CNT_BITS-1:0] cnt_next;
    logic sgate_reg;
    logic sgate_next;
    logic sclr_reg;
    logic sclr_next;
    logic fgate_reg;
    logic fgate_next;
    logic fclr_reg;
    logic fclr_next;
    vffpc_byte_t sdata_reg;
    vffpc_byte_t sdata_next;
    logic rd_reg;
    logic rd_next;
    logic vvalid_reg;
    logic vvalid_next;
    vffpc_byte_t vdata_reg;
    vffpc_byte_t vdata_next;
    logic taken;

    always_comb
    begin
        // Both pointers step every cycle once running and not parked, so their spacing is fixed.
        taken = i_field_start && (state_reg == VFFPC_IDLE || (state_reg == VFFPC_RUN && cnt_reg >= GAP));
        drain_ready = (state_reg != VFFPC_IDLE) || taken;
        state_next = state_reg;
        cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 1'b1;
        sgate_next = sgate_reg;
        sclr_next = 1'b1;
        fgate_next = fgate_reg;
        fclr_next = 1'b1;
        sdata_next = fifo_valid ? fifo_data : '0;
        if (state_reg == VFFPC_IDLE)
        begin
            cnt_next = '0;
        end
        if (taken)
        begin
            sgate_next = 1'b0;
            sclr_next = 1'b0;
            cnt_next = `VFFPC_CNT_BITS'(1);
            if (i_new_mode)
            begin
                state_next = VFFPC_LEAD;
            end
            else
            begin
                state_next = VFFPC_RUN;
                fgate_next = 1'b0;
                fclr_next = 1'b0;
            end
        end
        else if (state_reg == VFFPC_LEAD && cnt_reg == LEAD)
        begin
            state_next = VFFPC_RUN;
            fgate_next = 1'b0;
            fclr_next = 1'b0;
        end
        else if (state_reg == VFFPC_RUN && i_park)
        begin
            fclr_next = 1'b0;
        end
        rd_next = ~fgate_reg;
        vvalid_next = rd_reg & port.output_byte_oe;
        vdata_next = port.output_byte;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= VFFPC_IDLE;
            cnt_reg <= '0;
            sgate_reg <= 1'b1;
            sclr_reg <= 1'b1;
            fgate_reg <= 1'b1;
            fclr_reg <= 1'b1;
            sdata_reg <= '0;
            rd_reg <= 1'b0;
            vvalid_reg <= 1'b0;
            vdata_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sgate_reg <= sgate_next;
            sclr_reg <= sclr_next;
            fgate_reg <= fgate_next;
            fclr_reg <= fclr_next;
            sdata_reg <= sdata_next;
            rd_reg <= rd_next;
            vvalid_reg <= vvalid_next;
            vdata_reg <= vdata_next;
        end
    end

    assign port.input_byte = sdata_reg;
    assign port.store_gate_n = sgate_reg;
    assign port.store_pointer_clear_n = sclr_reg;
    assign port.fetch_gate_n = fgate_reg;
    assign port.fetch_pointer_clear_n = fclr_reg;
    assign port.output_drive_n = fgate_reg;
    assign o_start_taken = taken;
    assign o_vid_valid = vvalid_reg;
    assign o_vid_data = vdata_reg;
endmodule

// file: bench/vffpc_monitor.sv
// Checker on the pins between the field memory and its video logic.
`timescale 1ns/1ns
module vffpc_monitor
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link pins
    input wire logic store_gate_n,
    input wire logic store_pointer_clear_n,
    input wire logic fetch_gate_n,
    input wire logic fetch_pointer_clear_n,
    input wire logic output_drive_n,
    input wire vffpc_pkg::vffpc_byte_t output_byte,
    input wire logic output_byte_oe
);
    import vffpc_pkg::*;
    logic [9:0] scnt_reg, scnt_next, fcnt_reg, fcnt_next;

    // Words moved since the last clear; reset saturates them so the first clear is legal.
    always_comb
    begin
        scnt_next = scnt_reg;
        fcnt_next = fcnt_reg;
        if (!store_gate_n)
            scnt_next = store_pointer_clear_n ? scnt_reg + {9'h000, scnt_reg != 10'h3FF} : 10'h001;
        if (!fetch_gate_n)
            fcnt_next = fetch_pointer_clear_n ? fcnt_reg + {9'h000, fcnt_reg != 10'h3FF} : 10'h001;
    end

    always_ff @(posedge i_clk)
    begin
        scnt_reg <= i_rst ? 10'h3FF : scnt_next;
        fcnt_reg <= i_rst ? 10'h3FF : fcnt_next;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_store_clear_gap: assert property ($fell(store_pointer_clear_n) |-> scnt_reg >= 10'h052)
        else $error("store clear too soon");
    a_fetch_clear_gap: assert property ($fell(fetch_pointer_clear_n) |-> fcnt_reg >= 10'h052)
        else $error("fetch clear too soon");
    a_fetch_lead_min: assert property ($fell(fetch_pointer_clear_n) && store_pointer_clear_n |-> scnt_reg >= 10'h0C8)
        else $error("fetch started with short lead");
    a_gate_no_rise: assert property (!fetch_gate_n && !fetch_pointer_clear_n |=> !fetch_gate_n)
        else $error("fetch gate raised in clear cycle");
    a_oe_follows_drive: assert property (output_byte_oe == !$past(output_drive_n))
        else $error("output enable does not follow drive");
    a_out_hold_gated: assert property (fetch_gate_n |=> $stable(output_byte))
        else $error("output changed while fetch gated off");
    a_drive_tied_gate: assert property (output_drive_n == fetch_gate_n)
        else $error("drive not tied to fetch gate");
    a_reset_idle_pins: assert property ($past(i_rst) |-> store_gate_n && fetch_gate_n && store_pointer_clear_n
        && fetch_pointer_clear_n && !output_byte_oe)
        else $error("pins not idle after reset");

    cover property ($fell(store_pointer_clear_n) && $fell(fetch_pointer_clear_n));
    cover property ($fell(fetch_pointer_clear_n) && store_pointer_clear_n);
    cover property (!fetch_pointer_clear_n [*8]);
endmodule

// file: bench/tb_video_field_fifo_pointer_control.sv
// Self-checking bench joining both ends of the field memory link.
`timescale 1ns/1ns
module tb_video_field_fifo_pointer_control;
    import vffpc_pkg::*;
    localparam int DEPTH = 1000;
    logic i_clk, i_rst, i_pix_valid, i_field_start, i_new_mode, i_park;
    logic o_pix_ready, o_start_taken, o_vid_valid, exp_ok, vid_ok;
    vffpc_byte_t pix_reg, o_vid_data, exp_byte, vid_prev;
    logic [9:0] o_store_addr, o_fetch_addr;
    vffpc_byte_t model [0:DEPTH-1];
    logic known [0:DEPTH-1];
    int mismatches, num_checks, sidx, fa, sa;

    vffpc_if bus ();
    vffpc_device #(.DEPTH(DEPTH), .BLOCK(64)) vffpc_device_inst (.i_clk(i_clk), .i_rst(i_rst), .port(bus),
        .o_store_addr(o_store_addr), .o_fetch_addr(o_fetch_addr));
    vffpc_host vffpc_host_inst (.i_clk(i_clk), .i_rst(i_rst), .port(bus), .i_pix_valid(i_pix_valid),
        .i_pix_data(pix_reg), .o_pix_ready(o_pix_ready), .i_field_start(i_field_start), .i_new_mode(i_new_mode),
        .i_park(i_park), .o_start_taken(o_start_taken), .o_vid_valid(o_vid_valid), .o_vid_data(o_vid_data));
    vffpc_monitor vffpc_monitor_inst (.i_clk(i_clk), .i_rst(i_rst), .store_gate_n(bus.store_gate_n),
        .store_pointer_clear_n(bus.store_pointer_clear_n), .fetch_gate_n(bus.fetch_gate_n),
        .fetch_pointer_clear_n(bus.fetch_pointer_clear_n), .output_drive_n(bus.output_drive_n),
        .output_byte(bus.output_byte), .output_byte_oe(bus.output_byte_oe));

    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Reference memory; the fetch expectation is taken before this edge's store, so equal pointers read old data.
    always @(posedge i_clk)
    begin
        if (exp_ok) check(10'(bus.output_byte), 10'(exp_byte));
        if (o_vid_valid && vid_ok) check(10'(o_vid_data), 10'(vid_prev));
        vid_prev <= exp_byte;
        vid_ok <= exp_ok;
        fa = bus.fetch_pointer_clear_n ? int'(o_fetch_addr) : 0;
        sa = bus.store_pointer_clear_n ? int'(o_store_addr) : 0;
        exp_ok <= !i_rst && !bus.fetch_gate_n && known[fa];
        exp_byte <= model[fa];
        pix_reg <= i_rst ? 8'h00 : pix_reg + {7'h00, i_pix_valid && o_pix_ready};
        sidx <= i_rst ? 0 : sidx + int'(!bus.store_gate_n);
        if (!i_rst && !bus.store_gate_n)
        begin
            if (sidx < 16) check(10'(bus.input_byte), sidx[9:0]);
            if (!bus.store_pointer_clear_n && o_store_addr[5:0] != 6'h00)
            begin
                // A mid-block clear flushes the stale tail of the buffer over these words.
                for (int i = int'(o_store_addr); i < DEPTH && i <= (int'(o_store_addr) | 63); i++)
                    known[i] <= 1'b0;
            end
            model[sa] <= bus.input_byte;
            known[sa] <= 1'b1;
        end
    end

    task automatic reset_dut();
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        check({bus.store_gate_n, bus.store_pointer_clear_n, bus.fetch_gate_n, bus.fetch_pointer_clear_n,
            bus.output_byte_oe, 5'h00}, 10'h3C0);
        check(o_store_addr, 10'h000);
    endtask

    // The host does not drain while idle, so the buffer must refuse after exactly sixteen words.
    task automatic fill_fifo();
        repeat (40)
        begin
            @(posedge i_clk);
            #1;
            if (!o_pix_ready) break;
        end
        check(10'(pix_reg), 10'h010);
    endtask

    task automatic start_field(input logic mode);
        @(posedge i_clk);
        i_field_start <= 1'b1;
        i_new_mode <= mode;
        #1;
        check(10'(o_start_taken), 10'h001);
        @(posedge i_clk);
        i_field_start <= 1'b0;
        #1;
        check(10'({bus.store_pointer_clear_n, bus.fetch_pointer_clear_n}), {8'h00, 1'b0, mode});
    endtask

    task automatic delay_field();
        reset_dut();
        fill_fifo();
        start_field(1'b0);
        repeat (20) @(posedge i_clk);
        i_field_start <= 1'b1;
        #1;
        check(10'(o_start_taken), 10'h000);
        @(posedge i_clk);
        i_field_start <= 1'b0;
        repeat (1100)
        begin
            @(posedge i_clk);
            #1;
            if (o_store_addr == 10'h000) break;
        end
        check(o_store_addr, 10'h000);
        // Restart in mid-block so the clear must push out a partly filled block.
        repeat (100) @(posedge i_clk);
        start_field(1'b0);
        repeat (1100) @(posedge i_clk);
        #1;
        check(10'(o_vid_valid), 10'h001);
    endtask

    task automatic new_field();
        reset_dut();
        fill_fifo();
        start_field(1'b1);
        repeat (300)
        begin
            @(posedge i_clk);
            #1;
            if (!bus.fetch_pointer_clear_n) break;
        end
        check(10'(o_store_addr >= 10'h0C8), 10'h001);
        repeat (400) @(posedge i_clk);
        i_park <= 1'b1;
        repeat (30) @(posedge i_clk);
        i_park <= 1'b0;
        #1;
        check(10'(bus.fetch_pointer_clear_n), 10'h000);
        repeat (1200) @(posedge i_clk);
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        i_rst = 1'b1;
        i_pix_valid = 1'b1;
        i_field_start = 1'b0;
        i_new_mode = 1'b0;
        i_park = 1'b0;
        mismatches = 0;
        num_checks = 0;
        for (int i = 0; i < DEPTH; i++)
            known[i] = 1'b0;
        delay_field();
        new_field();
        end_sim();
    end

    initial
    begin
        #(40 * 10000);
        mismatches++;
        end_sim();
    end
endmodule
